// ==== include/nvmp_pkg.sv ====
// Constants, types and timing helpers for the parallel memory port controller
// Function
// RQ1: Memory holds 65,536 words of 16 bits
// RQ2: New row only at select fall or row change
// RQ3: Four words per row, reached without reselecting
// RQ4: Select fall latches address; write strobe high reads
// RQ5: Select high starts precharge; hold precharge_min_time
// RQ6: Row change under select restarts access internally
// RQ7: Random rows no faster than cycle times
// RQ8: Device drives only enabled byte lanes
// RQ9: Device holds bus undriven until data valid
// RQ10: Output drive high keeps bus undriven
// RQ11: Strobe low at select fall means write
// RQ12: Late strobe turns read into write, bus released
// RQ13: Write spans strobe fall to first rising edge
// RQ14: Host meets access time before ending write
// RQ15: One write strobe pulse per word
// RQ16: Writes commit within the bus cycle
// RQ17: Column change gives new read word quickly
// RQ18: Further strobe pulses write more row words
// RQ19: Sleep ignores all inputs except sleep pin
// RQ20: Finish accesses before sleep; wait after wake
// RQ21: Select may stay low across accesses
// RQ22: Keep write strobe high whenever select low idle
// RQ23: Byte selects gate reads and writes
// RQ24: Each strobe fall captures a fresh column
// RQ25: Host counts cycles, delays rounded up
package nvmp_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int ROW_W = 14;
   localparam int COL_W = 2;
   localparam int CNT_W = 8;
   localparam int T_ADDR_ACCESS_NS = 70;
   localparam int T_PAGE_ACCESS_NS = 30;
   localparam int T_PRECHARGE_NS = 70;
   localparam int T_READ_CYCLE_NS = 110;
   localparam int T_WRITE_CYCLE_NS = 110;
   localparam int T_SLEEP_EXIT_NS = 500;
   localparam int COL_LSB = 0;
   localparam int ROW_LSB = 2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RD = 3'h1,
      ST_WR = 3'h2,
      ST_WEND = 3'h3,
      ST_OPEN = 3'h4,
      ST_PRE = 3'h5,
      ST_SLEEP = 3'h6,
      ST_WAKE = 3'h7
   } nvmp_state_t;

   typedef struct packed {
      logic chip_select_n;
      logic write_strobe_n;
      logic output_drive_n;
      logic upper_byte_sel_n;
      logic lower_byte_sel_n;
      logic sleep_request_n;
      logic [ROW_W-1:0] row_address;
      logic [COL_W-1:0] column_address;
      logic [DATA_W-1:0] data_out;
      logic data_oe_n;
   } nvmp_pins_t;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [1:0] byte_en;
   } nvmp_req_t;

   // Minimum delay to whole clock cycles, never below one
   function automatic int nvmp_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
endpackage

// ==== logic/nvmp_host.sv ====
// Host controller that drives the parallel nonvolatile memory port
`timescale 1ns/1ps
module nvmp_host #(
   parameter int T_AA_NS = nvmp_pkg::T_ADDR_ACCESS_NS,
   parameter int T_AAP_NS = nvmp_pkg::T_PAGE_ACCESS_NS,
   parameter int T_PC_NS = nvmp_pkg::T_PRECHARGE_NS,
   parameter int T_RC_NS = nvmp_pkg::T_READ_CYCLE_NS,
   parameter int T_WC_NS = nvmp_pkg::T_WRITE_CYCLE_NS,
   parameter int T_ZZEX_NS = nvmp_pkg::T_SLEEP_EXIT_NS
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic req_valid,
   input wire nvmp_pkg::nvmp_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [nvmp_pkg::DATA_W-1:0] rsp_rdata,
   input wire logic sleep_req,
   output logic sleep_ack,
   output nvmp_pkg::nvmp_pins_t pins,
   input wire logic [nvmp_pkg::DATA_W-1:0] data_in
);
   import nvmp_pkg::*;

   localparam int AA_CYC = nvmp_cycles(T_AA_NS); // RQ25
   localparam int AAP_CYC = nvmp_cycles(T_AAP_NS);
   localparam int PC_CYC = nvmp_cycles(T_PC_NS);
   localparam int RC_CYC = nvmp_cycles(T_RC_NS);
   localparam int WC_CYC = nvmp_cycles(T_WC_NS);
   localparam int ZZEX_CYC = nvmp_cycles(T_ZZEX_NS);
   localparam logic [CNT_W-1:0] AA_C = CNT_W'(AA_CYC - 1);
   localparam logic [CNT_W-1:0] AAP_C = CNT_W'(AAP_CYC - 1);
   localparam logic [CNT_W-1:0] PC_C = CNT_W'(PC_CYC - 1);
   localparam logic [CNT_W-1:0] RC_C = CNT_W'(RC_CYC - 1);
   localparam logic [CNT_W-1:0] WC_C = CNT_W'(WC_CYC - 1);
   localparam logic [CNT_W-1:0] ZZEX_C = CNT_W'(ZZEX_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

   generate
      if (AA_CYC > 255 || AAP_CYC > 255 || PC_CYC > 255 || RC_CYC > 255 || WC_CYC > 255 || ZZEX_CYC > 255) begin : g_bad
         $error("Timing parameter needs more cycles than the counters hold");
      end
   endgenerate

   typedef struct packed {
      nvmp_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] cyc;
      logic page;
      logic pend;
      logic last_wr;
      nvmp_req_t cur;
      logic ready;
      logic rsp_valid;
      logic [DATA_W-1:0] rdata;
      logic ack;
      nvmp_pins_t pins;
   } nvmp_regs_t;

   localparam nvmp_pins_t PINS_RST = '{chip_select_n: 1'b1, write_strobe_n: 1'b1, output_drive_n: 1'b1,
      upper_byte_sel_n: 1'b1, lower_byte_sel_n: 1'b1, sleep_request_n: 1'b1, row_address: '0,
      column_address: '0, data_out: '0, data_oe_n: 1'b1};

   nvmp_regs_t s_reg;
   nvmp_regs_t s_next;
   logic take;

   assign take = req_valid && s_reg.ready;

   always_comb begin
      s_next = s_reg;
      s_next.rsp_valid = 1'b0;
      if (s_reg.cyc != CNT_MAX) begin
         s_next.cyc = s_reg.cyc + 8'h01;
      end
      s_next.cnt = s_reg.cnt + 8'h01;
      if (take) begin
         s_next.cur = req;
      end
      unique case (s_reg.st)
         ST_IDLE: begin
            if (take && !sleep_req) begin
               // Full address and direction set up with the select fall
               s_next.pins.chip_select_n = 1'b0; // RQ4
               s_next.pins.row_address = req.addr[ROW_LSB +: ROW_W]; // RQ2
               s_next.pins.column_address = req.addr[COL_LSB +: COL_W];
               s_next.pins.upper_byte_sel_n = !req.byte_en[1]; // RQ23
               s_next.pins.lower_byte_sel_n = !req.byte_en[0]; // RQ23
               s_next.pins.write_strobe_n = !req.write; // RQ11
               s_next.pins.output_drive_n = req.write; // RQ4
               s_next.pins.data_out = req.wdata;
               s_next.pins.data_oe_n = !req.write; // RQ11
               s_next.cnt = '0;
               s_next.cyc = '0;
               s_next.page = 1'b0;
               s_next.last_wr = req.write;
               s_next.st = req.write ? ST_WR : ST_RD;
            end else if (sleep_req) begin
               s_next.pins.sleep_request_n = 1'b0; // RQ20
               s_next.st = ST_SLEEP;
            end
         end
         ST_OPEN: begin
            if (take && req.addr[ROW_LSB +: ROW_W] == s_reg.pins.row_address) begin
               // Same row: page access without toggling select
               s_next.pins.column_address = req.addr[COL_LSB +: COL_W]; // RQ3
               s_next.pins.upper_byte_sel_n = !req.byte_en[1]; // RQ23
               s_next.pins.lower_byte_sel_n = !req.byte_en[0];
               s_next.pins.write_strobe_n = !req.write; // RQ18
               s_next.pins.output_drive_n = req.write;
               s_next.pins.data_out = req.wdata;
               s_next.pins.data_oe_n = !req.write; // RQ12
               s_next.last_wr = s_reg.last_wr | req.write;
               s_next.cnt = '0;
               s_next.page = 1'b1;
               s_next.st = req.write ? ST_WR : ST_RD;
            end else if (take || sleep_req) begin
               // Close the row and precharge before a new row or sleep
               s_next.pins.chip_select_n = 1'b1; // RQ5
               s_next.pend = take;
               s_next.cnt = '0;
               s_next.st = ST_PRE;
            end
         end
         ST_RD: begin
            if (s_reg.cnt == (s_reg.page ? AAP_C : AA_C)) begin // RQ17
               s_next.rsp_valid = 1'b1;
               s_next.rdata = data_in; // RQ9
               s_next.pins.output_drive_n = 1'b1; // RQ10
               s_next.st = ST_OPEN;
            end
         end
         ST_WR: begin
            if (s_reg.cnt == AA_C) begin // RQ14
               s_next.pins.write_strobe_n = 1'b1; // RQ13 RQ15
               s_next.st = ST_WEND;
            end
         end
         ST_WEND: begin
            s_next.pins.data_oe_n = 1'b1; // RQ16
            s_next.st = ST_OPEN;
         end
         ST_PRE: begin
            if (s_reg.cnt >= PC_C && s_reg.cyc >= (s_reg.last_wr ? WC_C : RC_C)) begin // RQ5 RQ7
               if (s_reg.pend) begin
                  s_next.pins.chip_select_n = 1'b0; // RQ2
                  s_next.pins.row_address = s_reg.cur.addr[ROW_LSB +: ROW_W];
                  s_next.pins.column_address = s_reg.cur.addr[COL_LSB +: COL_W];
                  s_next.pins.upper_byte_sel_n = !s_reg.cur.byte_en[1];
                  s_next.pins.lower_byte_sel_n = !s_reg.cur.byte_en[0];
                  s_next.pins.write_strobe_n = !s_reg.cur.write; // RQ11
                  s_next.pins.output_drive_n = s_reg.cur.write;
                  s_next.pins.data_out = s_reg.cur.wdata;
                  s_next.pins.data_oe_n = !s_reg.cur.write;
                  s_next.cnt = '0;
                  s_next.cyc = '0;
                  s_next.page = 1'b0;
                  s_next.pend = 1'b0;
                  s_next.last_wr = s_reg.cur.write;
                  s_next.st = s_reg.cur.write ? ST_WR : ST_RD;
               end else begin
                  s_next.st = ST_IDLE;
               end
            end
         end
         ST_SLEEP: begin
            if (!sleep_req) begin
               s_next.pins.sleep_request_n = 1'b1;
               s_next.cnt = '0;
               s_next.st = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (s_reg.cnt >= ZZEX_C) begin // RQ20
               s_next.st = ST_IDLE;
            end
         end
      endcase
      s_next.ack = (s_next.st == ST_SLEEP);
      s_next.ready = (s_next.st == ST_IDLE || s_next.st == ST_OPEN) && !sleep_req; // RQ20
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s_reg <= '{st: ST_IDLE, cnt: '0, cyc: CNT_MAX, page: 1'b0, pend: 1'b0, last_wr: 1'b0, cur: '0,
            ready: 1'b0, rsp_valid: 1'b0, rdata: '0, ack: 1'b0, pins: PINS_RST}; // RQ22
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   assign req_ready = s_reg.ready;
   assign rsp_valid = s_reg.rsp_valid;
   assign rsp_rdata = s_reg.rdata;
   assign sleep_ack = s_reg.ack;
   assign pins = s_reg.pins;

   // Helper counters seen only by the checks below
   logic [CNT_W-1:0] hi_cnt;
   logic [CNT_W-1:0] wlo_cnt;
   logic [CNT_W-1:0] wake_cnt;
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         hi_cnt <= CNT_MAX;
         wlo_cnt <= '0;
         wake_cnt <= CNT_MAX;
      end else if (clk_en) begin
         hi_cnt <= pins.chip_select_n ? ((hi_cnt == CNT_MAX) ? hi_cnt : hi_cnt + 8'h01) : 8'h00;
         wlo_cnt <= pins.write_strobe_n ? 8'h00 : wlo_cnt + 8'h01;
         wake_cnt <= !pins.sleep_request_n ? 8'h00 : ((wake_cnt == CNT_MAX) ? wake_cnt : wake_cnt + 8'h01);
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   bus_contention_a: assert property (!pins.data_oe_n |-> pins.output_drive_n) else $error("host drives data while device may drive"); // RQ11
   strobe_select_a: assert property (!pins.write_strobe_n |-> !pins.chip_select_n) else $error("write strobe low outside a cycle"); // RQ22
   precharge_hold_a: assert property ($fell(pins.chip_select_n) |-> hi_cnt >= 8'(PC_CYC)) else $error("precharge too short"); // RQ5
   // Select fall to select fall must span at least the shorter cycle time
   cycle_time_a: assert property ($fell(pins.chip_select_n) |-> $past(s_reg.cyc) >= ((RC_C < WC_C) ? RC_C : WC_C))
      else $error("cycle time not met"); // RQ7
   write_width_a: assert property ($rose(pins.write_strobe_n) |-> wlo_cnt >= 8'(AA_CYC)) else $error("write strobe too short"); // RQ14
   row_stable_a: assert property (!pins.chip_select_n && $past(!pins.chip_select_n) |-> $stable(pins.row_address)) else $error("row moved under select"); // RQ2
   // Column may only move out of a cycle in which the strobe was high
   column_strobe_a: assert property ($changed(pins.column_address) |-> $past(pins.write_strobe_n))
      else $error("column changed during write"); // RQ24
   sleep_quiet_a: assert property (!pins.sleep_request_n |-> pins.chip_select_n && pins.write_strobe_n) else $error("access during sleep"); // RQ20
   wake_delay_a: assert property ($fell(pins.chip_select_n) |-> wake_cnt >= 8'(ZZEX_CYC)) else $error("access too soon after wake"); // RQ20
   read_return_a: assert property ($fell(pins.output_drive_n) ##0 clk_en [*1] |-> ##[1:300] rsp_valid) else $error("read never returned"); // RQ17

   read_cov: cover property ($fell(pins.output_drive_n) ##[1:20] rsp_valid);
   write_cov: cover property ($fell(pins.write_strobe_n) ##[1:20] $rose(pins.write_strobe_n));
   page_cov: cover property (s_reg.st == ST_RD && s_reg.page);
   sleep_cov: cover property ($fell(pins.sleep_request_n) ##[1:50] $rose(pins.sleep_request_n));
endmodule

// ==== tb/nvmp_mem_model.sv ====
// Behavioural model of the 64K x 16 nonvolatile memory behind the port
`timescale 1ns/1ps
module nvmp_mem_model
   import nvmp_pkg::*;
#(
   parameter int ACC_CYC = 1
) (
   input wire logic mclk,
   input wire nvmp_pkg::nvmp_pins_t pins,
   output logic [nvmp_pkg::DATA_W-1:0] data_in
);
   logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];
   logic [ROW_W-1:0] row_reg = '0;
   int acc_cnt = 0;
   logic wr_pend = 1'b0;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [1:0] wr_be;
   logic [DATA_W-1:0] last_q = '0;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] word;
   logic drive;
   assign rd_addr = {pins.row_address, pins.column_address};
   initial begin
      for (int i = 0; i < (1 << ADDR_W); i++) begin
         mem[i] = '0;
      end
   end
   assign word = mem[rd_addr];
   // Drive only in an awake read with data valid and output drive low
   assign drive = pins.sleep_request_n && !pins.chip_select_n && pins.write_strobe_n && !pins.output_drive_n
      && acc_cnt >= ACC_CYC;
   // Undriven lanes show the inverse of their last level
   assign data_in[15:8] = (drive && !pins.upper_byte_sel_n) ? word[15:8] : ~last_q[15:8];
   assign data_in[7:0] = (drive && !pins.lower_byte_sel_n) ? word[7:0] : ~last_q[7:0];
   always @(posedge mclk) begin
      last_q <= data_in;
      if (pins.sleep_request_n) begin
         if (pins.chip_select_n) begin
            acc_cnt <= 0;
            row_reg <= pins.row_address;
         end else if (pins.row_address != row_reg) begin
            acc_cnt <= 1;
            row_reg <= pins.row_address;
         end else begin
            acc_cnt <= acc_cnt + 1;
         end
         if (!pins.chip_select_n && !pins.write_strobe_n) begin
            wr_pend <= 1'b1;
            wr_addr <= rd_addr;
            wr_data <= pins.data_out;
            wr_be <= ~{pins.upper_byte_sel_n, pins.lower_byte_sel_n};
         end else if (wr_pend) begin
            wr_pend <= 1'b0;
            if (wr_be[1]) begin
               mem[wr_addr][15:8] <= wr_data[15:8];
            end
            if (wr_be[0]) begin
               mem[wr_addr][7:0] <= wr_data[7:0];
            end
         end
      end
   end
endmodule

// ==== tb/tb_nvmp_host.sv ====
// Self-checking bench for the parallel memory port host controller
`timescale 1ns/1ps
module tb_nvmp_host;
   import nvmp_pkg::*;
   logic mclk, rstn, clk_en, req_valid, sleep_req, req_ready, rsp_valid, sleep_ack;
   nvmp_req_t req;
   logic [DATA_W-1:0] rsp_rdata, data_in, rd;
   nvmp_pins_t pins, snap;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   nvmp_host nvmp_host_inst (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sleep_req(sleep_req),
      .sleep_ack(sleep_ack), .pins(pins), .data_in(data_in));
   nvmp_mem_model nvmp_mem_model_inst (.mclk(mclk), .pins(pins), .data_in(data_in));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   // One request; a read waits for its word, bounded
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req <= '{wr, a, d, be};
      do @(posedge mclk); while (!(req_ready === 1'b1 && clk_en) && ++n < 400);
      req_valid <= 1'b0;
      if (!wr) begin
         do @(posedge mclk); while (rsp_valid !== 1'b1 && ++n < 400);
         rd = rsp_rdata;
      end else begin
         // Let an edge pass so the next request is not driven in this time step
         @(posedge mclk);
      end
      if (n >= 400) num_errors++;
   endtask
   task automatic s_reset();
      chk16("idle pins", 16'h003f, {10'h0, pins.chip_select_n, pins.write_strobe_n, pins.output_drive_n,
         pins.upper_byte_sel_n, pins.lower_byte_sel_n, pins.data_oe_n});
   endtask
   task automatic s_write_read();
      xfer(1'b1, 16'h1234, 16'hbeef, 2'b11);
      xfer(1'b0, 16'h1234, 16'h0000, 2'b11);
      chk16("read after write", 16'hbeef, rd);
   endtask
   task automatic s_page();
      xfer(1'b1, 16'h1235, 16'ha5a5, 2'b11);
      xfer(1'b1, 16'h1237, 16'h5a5a, 2'b11);
      xfer(1'b0, 16'h1235, 16'h0000, 2'b11);
      chk16("page read col1", 16'ha5a5, rd);
      xfer(1'b0, 16'h1237, 16'h0000, 2'b11);
      chk16("page read col3", 16'h5a5a, rd);
      xfer(1'b0, 16'h1234, 16'h0000, 2'b11);
      chk16("page read col0", 16'hbeef, rd);
   endtask
   task automatic s_bytes();
      xfer(1'b1, 16'h1234, 16'h1111, 2'b01);
      xfer(1'b1, 16'h1235, 16'h2222, 2'b10);
      xfer(1'b0, 16'h1234, 16'h0000, 2'b11);
      chk16("lower lane write", 16'hbe11, rd);
      xfer(1'b0, 16'h1235, 16'h0000, 2'b11);
      chk16("upper lane write", 16'h22a5, rd);
      xfer(1'b0, 16'h1234, 16'h0000, 2'b10);
      chk16("upper lane read", 16'h00be, {8'h00, rd[15:8]});
   endtask
   task automatic s_rows();
      xfer(1'b1, 16'h8001, 16'hc3c3, 2'b11);
      xfer(1'b0, 16'h1237, 16'h0000, 2'b11);
      chk16("row change back", 16'h5a5a, rd);
      xfer(1'b0, 16'h8001, 16'h0000, 2'b11);
      chk16("row change read", 16'hc3c3, rd);
   endtask
   task automatic s_freeze();
      clk_en <= 1'b0;
      req_valid <= 1'b1;
      req <= '{1'b0, 16'h1234, 16'h0000, 2'b11};
      @(posedge mclk);
      snap = pins;
      repeat (5) @(posedge mclk);
      chk16("frozen pins", snap[15:0], pins[15:0]);
      chk16("frozen select", {15'h0, snap.chip_select_n}, {15'h0, pins.chip_select_n});
      clk_en <= 1'b1;
      xfer(1'b0, 16'h1234, 16'h0000, 2'b11);
      chk16("read after freeze", 16'hbe11, rd);
   endtask
   task automatic s_sleep();
      int n;
      n = 0;
      sleep_req <= 1'b1;
      do @(posedge mclk); while (sleep_ack !== 1'b1 && ++n < 100);
      chk16("sleep pins", 16'h0001, {14'h0, pins.sleep_request_n, pins.chip_select_n});
      chk16("sleep ack", 16'h0001, {15'h0, sleep_ack});
      repeat (3) @(posedge mclk);
      sleep_req <= 1'b0;
      xfer(1'b0, 16'h8001, 16'h0000, 2'b11);
      chk16("read after wake", 16'hc3c3, rd);
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   initial begin
      rstn = 1'b0;
      clk_en = 1'b1;
      req_valid = 1'b0;
      req = '0;
      sleep_req = 1'b0;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      s_reset();
      s_write_read();
      s_page();
      s_bytes();
      s_rows();
      s_freeze();
      s_sleep();
      end_of_test();
   end
endmodule
